// file: rtl/cmp_pkg.sv
// Package of register layout and constants for the comparator register bank
package cmp_pkg;
    localparam int          NUM_CMP        = 3;
    localparam int          AW             = 4;
    localparam int          DW             = 16;
    // Register offsets
    localparam logic [3:0]  OFS_CTRL1      = 4'h0;
    localparam logic [3:0]  OFS_CTRL2      = 4'h1;
    localparam logic [3:0]  OFS_CTRL3      = 4'h2;
    localparam logic [3:0]  OFS_STATUS     = 4'h3;
    localparam logic [3:0]  OFS_IRQ_STAT   = 4'h4;
    localparam logic [3:0]  OFS_IRQ_CLR    = 4'h5;
    localparam logic [3:0]  OFS_IRQ_EN     = 4'h6;
    // Control register field positions
    localparam int          CTL_EVT_BIT    = 9;
    localparam int          CTL_OUT_BIT    = 8;
    localparam int          CTL_REF_BIT    = 4;
    localparam int          CTL_CCH_LSB    = 0;
    // Status register field positions
    localparam int          ST_IDL_BIT     = 15;
    localparam int          ST_EVT_LSB     = 8;
    localparam int          ST_OUT_LSB     = 0;
    // Reset values
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [15:0] STATUS_RST     = 16'h0000;
    localparam logic [2:0]  IRQ_RST        = 3'h0;
    // Inverting input channel codes
    localparam logic [1:0]  CCH_PIN_B      = 2'h0;
    localparam logic [1:0]  CCH_PIN_C      = 2'h1;
    localparam logic [1:0]  CCH_PIN_D      = 2'h2;
    localparam logic [1:0]  CCH_REF        = 2'h3;
    // Route selects towards the analog side
    typedef enum logic [1:0] {
        CMP_INV_PIN_B = 2'h0,
        CMP_INV_PIN_C = 2'h1,
        CMP_INV_PIN_D = 2'h3,
        CMP_INV_REF   = 2'h2
    } cmp_inv_sel_t;
endpackage : cmp_pkg

// file: rtl/cmp_route_if.sv
// Interface carrying one comparator's register fields to its router
`timescale 1ns/1ps
interface cmp_route_if;
    logic               ref_sel;
    logic [1:0]         cch;
    logic               noninv_ref;
    cmp_pkg::cmp_inv_sel_t inv_sel;
    modport ctl (output ref_sel, output cch, input noninv_ref, input inv_sel);
    modport rte (input ref_sel, input cch, output noninv_ref, output inv_sel);
endinterface : cmp_route_if

// file: rtl/cmp_route.sv
// Input route decoder for one comparator
`timescale 1ns/1ps
module cmp_route (
    cmp_route_if.rte    rt
);
    import cmp_pkg::*;

    // Non-inverting: 1 selects internal reference, 0 selects pin A
    assign rt.noninv_ref = rt.ref_sel;

    // Inverting channel decode
    assign rt.inv_sel = (rt.cch == CCH_REF)   ? CMP_INV_REF   :
                        (rt.cch == CCH_PIN_D) ? CMP_INV_PIN_D :
                        (rt.cch == CCH_PIN_C) ? CMP_INV_PIN_C : CMP_INV_PIN_B;
endmodule : cmp_route

// file: rtl/cmp_regs.sv
// Comparator control, status and interrupt register bank
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - When the idle-halt bit 15 of the status register is 1, all comparators stop in Idle.
// - Status bits 10..8 mirror the event flags (control bit 9) of comparators 3..1.
// - Status bits 2..0 mirror the outputs (control bit 8) of comparators 3..1.
// - The mirrored event and output bits change by hardware only, never by software.
// - Status bits 14..11 and 7..3 always read as zero.
// - Control bit 4 routes the non-inverting input to the reference (1) or pin A (0).
// - Control bits 1:0 route the inverting input: 11 ref, 10 pin D, 01 pin C, 00 pin B.
// - Control bits 3 and 2 always read as zero.
module cmp_regs (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register port
    input  wire logic [cmp_pkg::AW-1:0]  addr,
    input  wire logic [cmp_pkg::DW-1:0]  wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [cmp_pkg::DW-1:0]  rdata,
    // Comparator cores
    input  wire logic [2:0]              cmp_out,
    input  wire logic [2:0]              cmp_evt,
    input  wire logic                    idle_mode,
    output logic      [2:0]              cmp_run,
    output logic      [2:0]              noninv_ref,
    output logic      [5:0]              inv_sel,
    // Interrupt
    output logic                         irq
);
    import cmp_pkg::*;

    // Register state
    logic       [2:0]  ref_ff;
    logic       [5:0]  cch_ff;
    logic       [2:0]  out_ff;
    logic       [2:0]  evt_ff;
    logic              idl_ff;
    logic       [2:0]  ist_ff;
    logic       [2:0]  ien_ff;
    logic       [15:0] rdata_ff;
    logic              irq_ff;
    logic       [2:0]  run_ff;
    logic       [2:0]  nref_ff;
    logic       [5:0]  isel_ff;
    logic       [15:0] nxt_rdata;
    logic       [2:0]  nxt_ist;
    logic       [2:0]  evt_rise;
    logic       [2:0]  wr_ctrl;
    logic       [15:0] ctrl_rd [NUM_CMP];
    logic       [15:0] status_rd;
    logic       [2:0]  rt_nref;
    logic       [5:0]  rt_isel;

    // Control register read image
    function automatic logic [15:0] ctrl_word(input logic e, input logic o,
                                              input logic r, input logic [1:0] c);
        logic [15:0] w;
        w = 16'h0000;
        w[CTL_EVT_BIT] = e;
        w[CTL_OUT_BIT] = o;
        w[CTL_REF_BIT] = r;
        w[CTL_CCH_LSB +: 2] = c;
        return w;
    endfunction : ctrl_word

    // Per-comparator write decode, read image and route decoder
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            cmp_route_if rif ();
            assign rif.ref_sel = ref_ff[g];
            assign rif.cch     = cch_ff[2*g +: 2];
            assign rt_nref[g]       = rif.noninv_ref;
            assign rt_isel[2*g +: 2] = rif.inv_sel;
            cmp_route u_route (
                .rt (rif.rte)
            );
            assign wr_ctrl[g] = wr && (addr == OFS_CTRL1 + 4'(g));
            assign ctrl_rd[g] = ctrl_word(evt_ff[g], out_ff[g], ref_ff[g],
                                          cch_ff[2*g +: 2]);
        end
    endgenerate

    // Status image: unimplemented bits zero
    assign status_rd = {idl_ff, 4'h0, evt_ff, 5'h00, out_ff};

    // Read mux
    assign nxt_rdata = (addr == OFS_CTRL1)    ? ctrl_rd[0] :
                       (addr == OFS_CTRL2)    ? ctrl_rd[1] :
                       (addr == OFS_CTRL3)    ? ctrl_rd[2] :
                       (addr == OFS_STATUS)   ? status_rd  :
                       (addr == OFS_IRQ_STAT) ? {13'h0000, ist_ff} :
                       (addr == OFS_IRQ_EN)   ? {13'h0000, ien_ff} : 16'h0000;

    // Event sticky bits: set wins over clear
    assign evt_rise = cmp_evt & ~evt_ff;
    assign nxt_ist  = (ist_ff & ~((wr && addr == OFS_IRQ_CLR) ? wdata[2:0] : 3'h0))
                      | evt_rise;

    // Writable control fields
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_ff <= {NUM_CMP{CTRL_RST[CTL_REF_BIT]}};
            cch_ff <= {NUM_CMP{CTRL_RST[CTL_CCH_LSB +: 2]}};
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                if (wr_ctrl[i]) begin
                    ref_ff[i]         <= wdata[CTL_REF_BIT];
                    cch_ff[2*i +: 2]  <= wdata[CTL_CCH_LSB +: 2];
                end
            end
        end
    end

    // Status idle bit and hardware mirrors
    always_ff @(posedge clk) begin
        if (rst) begin
            idl_ff <= STATUS_RST[ST_IDL_BIT];
            out_ff <= STATUS_RST[ST_OUT_LSB +: 3];
            evt_ff <= STATUS_RST[ST_EVT_LSB +: 3];
        end else begin
            if (wr && addr == OFS_STATUS) begin
                idl_ff <= wdata[ST_IDL_BIT];
            end
            out_ff <= cmp_out;
            evt_ff <= cmp_evt;
        end
    end

    // Interrupt status and enable
    always_ff @(posedge clk) begin
        if (rst) begin
            ist_ff <= IRQ_RST;
            ien_ff <= IRQ_RST;
        end else begin
            ist_ff <= nxt_ist;
            if (wr && addr == OFS_IRQ_EN) begin
                ien_ff <= wdata[2:0];
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
            irq_ff   <= 1'b0;
            run_ff   <= 3'h0;
            nref_ff  <= 3'h0;
            isel_ff  <= 6'h00;
        end else begin
            rdata_ff <= rd ? nxt_rdata : 16'h0000;
            irq_ff   <= |(nxt_ist & ien_ff);
            run_ff   <= (idl_ff && idle_mode) ? 3'h0 : 3'h7;
            nref_ff  <= rt_nref;
            isel_ff  <= rt_isel;
        end
    end

    assign rdata      = rdata_ff;
    assign irq        = irq_ff;
    assign cmp_run    = run_ff;
    assign noninv_ref = nref_ff;
    assign inv_sel    = isel_ff;

    // Checks
    AST_IDLE_STOP: assert property (@(posedge clk) disable iff (rst)
        (idl_ff && idle_mode) |=> (cmp_run == 3'h0))
        else $error("comparators run in idle with halt set");
    AST_IDLE_RUN: assert property (@(posedge clk) disable iff (rst)
        (!idl_ff) |=> (cmp_run == 3'h7))
        else $error("comparators stopped without halt");
    AST_EVT_MIRROR: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == OFS_STATUS) ##1 1 |-> rdata[10:8] == $past(evt_ff))
        else $error("event mirror wrong");
    AST_OUT_MIRROR: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_STATUS |=> rdata[2:0] == $past(cmp_out, 2))
        else $error("output mirror wrong");
    AST_HW_ONLY: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == OFS_STATUS) |=> (out_ff == $past(cmp_out)))
        else $error("software changed a mirror bit");
    AST_ST_ZERO: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_STATUS |=> rdata[14:11] == 4'h0 && rdata[7:3] == 5'h00)
        else $error("unused status bits not zero");
    AST_NREF: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl[0] ##1 !wr_ctrl[0] |=> noninv_ref[0] == $past(wdata[CTL_REF_BIT], 2))
        else $error("noninverting route wrong");
    AST_INV_D: assert property (@(posedge clk) disable iff (rst)
        (cch_ff[3:2] == CCH_PIN_D) |=> inv_sel[3:2] == CMP_INV_PIN_D)
        else $error("inverting route wrong");
    AST_CTRL_ZERO: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CTRL1 |=> rdata[3:2] == 2'h0)
        else $error("unused control bits not zero");
    AST_WR_UPD: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl[1] |=> cch_ff[3:2] == $past(wdata[1:0]))
        else $error("control write not taken");

    // Access steps shared by the checks below
    sequence s_rd_status;
        rd && addr == OFS_STATUS;
    endsequence : s_rd_status
    sequence s_wr_status;
        wr && addr == OFS_STATUS;
    endsequence : s_wr_status
    sequence s_wr_clear;
        wr && addr == OFS_IRQ_CLR;
    endsequence : s_wr_clear

    // Halt bit alone does not stop the cores outside Idle
    AST_IDLE_ACT: assert property (@(posedge clk) disable iff (rst)
        (idl_ff && !idle_mode) |=> (cmp_run == 3'h7))
        else $error("comparators stopped outside idle");
    // Halt bit reads back at the top of the status word
    AST_IDL_RD: assert property (@(posedge clk) disable iff (rst)
        s_rd_status |=> rdata[ST_IDL_BIT] == $past(idl_ff))
        else $error("halt bit read wrong");
    // Event flag of comparator 2 in its own control word
    AST_EVT_CTRL: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CTRL2 |=> rdata[CTL_EVT_BIT] == $past(evt_ff[1]))
        else $error("control event bit wrong");
    // Output of comparator 3 in its own control word
    AST_OUT_CTRL: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CTRL3 |=> rdata[CTL_OUT_BIT] == $past(out_ff[2]))
        else $error("control output bit wrong");
    // Status write leaves the event mirror to the cores
    AST_EVT_HW: assert property (@(posedge clk) disable iff (rst)
        s_wr_status |=> evt_ff == $past(cmp_evt))
        else $error("software changed an event mirror");
    // Route of comparator 3 follows its reference bit
    AST_NREF3: assert property (@(posedge clk) disable iff (rst)
        ref_ff[2] |=> noninv_ref[2])
        else $error("comparator 3 not on reference");
    // Inverting routes: pin B, pin C and reference codes
    AST_INV_B: assert property (@(posedge clk) disable iff (rst)
        (cch_ff[1:0] == CCH_PIN_B) |=> inv_sel[1:0] == CMP_INV_PIN_B)
        else $error("pin B route wrong");
    AST_INV_C: assert property (@(posedge clk) disable iff (rst)
        (cch_ff[3:2] == CCH_PIN_C) |=> inv_sel[3:2] == CMP_INV_PIN_C)
        else $error("pin C route wrong");
    AST_INV_REF3: assert property (@(posedge clk) disable iff (rst)
        (cch_ff[5:4] == CCH_REF) |=> inv_sel[5:4] == CMP_INV_REF)
        else $error("reference route wrong");
    // Unused control bits of comparator 3
    AST_CTRL3_ZERO: assert property (@(posedge clk) disable iff (rst)
        rd && addr == OFS_CTRL3 |=> rdata[3:2] == 2'h0)
        else $error("unused control bits of comparator 3 not zero");
    // Comparator 1 control writes leave both mirrors alone
    AST_CTRL_RO: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl[0] |=> evt_ff == $past(cmp_evt) && out_ff == $past(cmp_out))
        else $error("control write reached a mirror");
    // Reference bit of comparator 3 takes the written value
    AST_WR_REF: assert property (@(posedge clk) disable iff (rst)
        wr_ctrl[2] |=> ref_ff[2] == $past(wdata[CTL_REF_BIT]))
        else $error("reference bit write not taken");
    // Halt bit takes the written value
    AST_ST_IDL: assert property (@(posedge clk) disable iff (rst)
        s_wr_status |=> idl_ff == $past(wdata[ST_IDL_BIT]))
        else $error("halt bit write not taken");
    // Interrupt level follows enabled sticky bits
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
        $stable(ien_ff) |-> irq == |(ist_ff & ien_ff))
        else $error("interrupt level wrong");
    // Clear without a new event drops the sticky bit
    AST_IRQ_CLR: assert property (@(posedge clk) disable iff (rst)
        s_wr_clear ##0 (wdata[0] && !evt_rise[0]) |=> !ist_ff[0])
        else $error("sticky bit not cleared");
endmodule : cmp_regs

// file: tb/cmp_core_model.sv
// Behavioural model of the three comparator cores
`timescale 1ns/1ps
module cmp_core_model (
    // Clock
    input  wire logic       clk,
    // Commanded comparator states
    input  wire logic [2:0] tgt_out,
    input  wire logic [2:0] tgt_evt,
    // Run permission from the register bank
    input  wire logic [2:0] cmp_run,
    // Core results
    output logic      [2:0] cmp_out,
    output logic      [2:0] cmp_evt
);
    initial begin
        cmp_out = 3'h0;
        cmp_evt = 3'h0;
    end
    // A halted core freezes its output and event flag
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (cmp_run[i] === 1'b1) begin
                cmp_out[i] <= tgt_out[i];
                cmp_evt[i] <= tgt_evt[i];
            end
        end
    end
endmodule : cmp_core_model

// file: tb/cmp_regs_bench.sv
// Self-checking bench for the comparator register bank
`timescale 1ns/1ps
module cmp_regs_bench;
    import cmp_pkg::*;
    logic          clk, rst, wr, rd, idle_mode, irq;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    logic [2:0]    cmp_out, cmp_evt, cmp_run, noninv_ref, tgt_out, tgt_evt;
    logic [5:0]    inv_sel;
    logic [1:0]    gry [4];
    int            bad_count, cmp_count;

    cmp_regs i_cmp_regs (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cmp_out(cmp_out), .cmp_evt(cmp_evt), .idle_mode(idle_mode),
        .cmp_run(cmp_run), .noninv_ref(noninv_ref), .inv_sel(inv_sel), .irq(irq));
    cmp_core_model i_cmp_core_model (.clk(clk), .tgt_out(tgt_out), .tgt_evt(tgt_evt),
        .cmp_run(cmp_run), .cmp_out(cmp_out), .cmp_evt(cmp_evt));

    // Clock of 5 ns
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk
    task automatic t_mirror;
        tgt_out <= 3'h5;
        tgt_evt <= 3'h2;
        cyc(3);
        rd_chk(OFS_STATUS, 16'h0205);
        rd_chk(OFS_CTRL1, 16'h0100);
        rd_chk(OFS_CTRL2, 16'h0200);
        rd_chk(OFS_CTRL3, 16'h0100);
        wr_reg(OFS_STATUS, 16'h7fff);
        rd_chk(OFS_STATUS, 16'h0205);
        wr_reg(OFS_CTRL1, 16'hffff);
        rd_chk(OFS_CTRL1, 16'h0113);
        chk({15'h0, noninv_ref[0]}, 16'h0001);
        chk({14'h0, inv_sel[1:0]}, {14'h0, CMP_INV_REF});
        wr_reg(OFS_CTRL1, 16'h0000);
        rd_chk(OFS_CTRL1, 16'h0100);
        chk({15'h0, noninv_ref[0]}, 16'h0000);
        chk({14'h0, inv_sel[1:0]}, {14'h0, CMP_INV_PIN_B});
    endtask : t_mirror
    task automatic t_route;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 4; c++) begin
                wr_reg(OFS_CTRL2, {11'h0, r[0], 2'h0, c[1:0]});
                cyc(2);
                #1 chk({15'h0, noninv_ref[1]}, {15'h0, r[0]});
                chk({14'h0, inv_sel[3:2]}, {14'h0, gry[c]});
            end
        end
        wr_reg(OFS_CTRL3, 16'h0013);
        cyc(2);
        #1 chk({15'h0, noninv_ref[2]}, 16'h0001);
        chk({14'h0, inv_sel[5:4]}, {14'h0, CMP_INV_REF});
        rd_chk(OFS_CTRL3, 16'h0113);
    endtask : t_route
    task automatic t_idle;
        wr_reg(OFS_STATUS, 16'h8000);
        idle_mode <= 1'b1;
        cyc(3);
        #1 chk({13'h0, cmp_run}, 16'h0000);
        tgt_out <= 3'h2;
        cyc(3);
        rd_chk(OFS_STATUS, 16'h8205);
        @(posedge clk);
        idle_mode <= 1'b0;
        cyc(4);
        #1 chk({13'h0, cmp_run}, 16'h0007);
        rd_chk(OFS_STATUS, 16'h8202);
        wr_reg(OFS_STATUS, 16'h0000);
        idle_mode <= 1'b1;
        cyc(3);
        #1 chk({13'h0, cmp_run}, 16'h0007);
    endtask : t_idle
    task automatic t_irq;
        rd_chk(OFS_IRQ_STAT, 16'h0002);
        chk({15'h0, irq}, 16'h0000);
        wr_reg(OFS_IRQ_EN, 16'h0001);
        tgt_evt <= 3'h3;
        cyc(4);
        #1 chk({15'h0, irq}, 16'h0001);
        wr_reg(OFS_IRQ_CLR, 16'h0001);
        cyc(2);
        #1 chk({15'h0, irq}, 16'h0000);
        rd_chk(OFS_IRQ_STAT, 16'h0002);
        rd_chk(OFS_IRQ_EN, 16'h0001);
        rd_chk(4'hf, 16'h0000);
    endtask : t_irq
    // Watchdog
    initial begin
        #20000;
        bad_count++;
        final_report();
    end
    // Main sequence
    initial begin
        gry = '{CMP_INV_PIN_B, CMP_INV_PIN_C, CMP_INV_PIN_D, CMP_INV_REF};
        {wr, rd, idle_mode, addr, wdata, tgt_out, tgt_evt} = '0;
        bad_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        cyc(3);
        rst <= 1'b0;
        #1 chk({13'h0, cmp_run}, 16'h0000);
        chk(rdata, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        rd_chk(OFS_STATUS, STATUS_RST);
        rd_chk(OFS_CTRL1, CTRL_RST);
        chk({13'h0, cmp_run}, 16'h0007);
        t_mirror();
        t_route();
        t_idle();
        t_irq();
        final_report();
    end
endmodule : cmp_regs_bench
